// ===== include/ats_cmd_pkg.sv
// constants and types for the endpoint invalidate, page response and access table command block
package ats_cmd_pkg;

  // ==========================================================
  // register map, byte offsets on the bus
  localparam logic [4:0] OFF_CONFIG = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h04;
  localparam logic [4:0] OFF_STREAM = 5'h08;
  localparam logic [4:0] OFF_SUBSTREAM = 5'h0c;
  localparam logic [4:0] OFF_ADDR_LO = 5'h10;
  localparam logic [4:0] OFF_ADDR_HI = 5'h14;
  localparam logic [4:0] OFF_ISSUE = 5'h18;
  localparam logic [4:0] OFF_STATUS = 5'h1c;

  // ==========================================================
  // reset values
  localparam logic [31:0] CONFIG_RST = 32'h0030_0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ==========================================================
  // config register fields
  localparam int CFG_ATS = 0;
  localparam int CFG_R_ATS = 1;
  localparam int CFG_PRI = 2;
  localparam int CFG_PASID = 3;
  localparam int CFG_DPT = 4;
  localparam int CFG_R_DPT = 5;
  localparam int CFG_SAD = 6;
  localparam int CFG_SYS_ATS = 7;
  localparam int CFG_SYS_PRI = 8;
  localparam int CFG_TEN_NS = 9;
  localparam int CFG_TEN_S = 10;
  localparam int CFG_TEN_R = 11;
  localparam int CFG_OAS_LSB = 16;

  // ==========================================================
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_Q_LSB = 4;
  localparam int CMD_SSV = 6;
  localparam int CMD_GLOBAL = 7;
  localparam int CMD_RESP_LSB = 8;
  localparam int CMD_SIZE_LSB = 10;
  localparam int CMD_DSIZE_LSB = 16;
  localparam int CMD_LEAF = 20;
  localparam int CMD_PRG_LSB = 21;

  // ==========================================================
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILL = 1;
  localparam int STAT_SYNC = 2;
  localparam int STAT_PEND_LSB = 8;
  localparam int STAT_UR_LSB = 16;
  localparam int CNT_W = 8;

  // ==========================================================
  // codes
  localparam logic [1:0] Q_NS = 2'h0;
  localparam logic [1:0] Q_SEC = 2'h1;
  localparam logic [1:0] Q_REALM = 2'h2;
  localparam logic [2:0] OP_ATC_INV = 3'h1;
  localparam logic [2:0] OP_PRI_RESP = 3'h2;
  localparam logic [2:0] OP_DPT_ALL = 3'h3;
  localparam logic [2:0] OP_DPT_RANGE = 3'h4;
  localparam logic [2:0] OP_SYNC = 3'h5;
  localparam logic [1:0] RESP_RESERVED = 2'h3;
  localparam logic KIND_INV = 1'b0;
  localparam logic KIND_PRG = 1'b1;
  localparam logic [6:0] PAGE_SHIFT = 7'h0c;
  localparam logic [5:0] ATS_SIZE_MAX = 6'h34;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND, ST_SYNC} state_e;

  // range size code to log2 of span; bit 6 marks a defined code
  function automatic logic [6:0] dpt_span(input logic [3:0] code);
    logic [6:0] s;
    s = 7'h00;
    case (code)
      4'h0: s = 7'h4c;
      4'h1: s = 7'h4e;
      4'h2: s = 7'h50;
      4'h3: s = 7'h55;
      4'h4: s = 7'h59;
      4'h5: s = 7'h5d;
      4'h6: s = 7'h5e;
      4'h7: s = 7'h62;
      4'h8: s = 7'h64;
      4'h9: s = 7'h67;
      default: s = 7'h00;
    endcase
    return s;
  endfunction : dpt_span

endpackage : ats_cmd_pkg

// ===== rtl/ats_inval_tracker.sv
// counter of outstanding endpoint invalidations and unsupported-request answers
`timescale 1ns/1ps
module ats_inval_tracker (
  input wire logic clk_in, // clock
  input wire logic rst_in, // async reset, high
  input wire logic sent_in, // one invalidation accepted by the port
  input wire logic cpl_valid_in, // one completion returned
  input wire logic cpl_ur_in, // completion was unsupported request
  output logic [ats_cmd_pkg::CNT_W-1:0] pend_out, // outstanding count
  output logic [ats_cmd_pkg::CNT_W-1:0] ur_out // unsupported answers seen
);
  import ats_cmd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] pend;
    logic [CNT_W-1:0] ur;
  } trk_s;

  trk_s trk_reg;
  trk_s trk_next;

  always_comb begin
    trk_next = trk_reg;
    if (sent_in && !cpl_valid_in) begin
      trk_next.pend = trk_reg.pend + CNT_W'(1);
    end else if (!sent_in && cpl_valid_in && trk_reg.pend != '0) begin
      trk_next.pend = trk_reg.pend - CNT_W'(1);
    end
    // an unsupported answer still completes; it is only counted
    if (cpl_valid_in && cpl_ur_in) begin
      trk_next.ur = trk_reg.ur + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trk_reg <= '0;
    end else begin
      trk_reg <= trk_next;
    end
  end

  assign pend_out = trk_reg.pend;
  assign ur_out = trk_reg.ur;

endmodule : ats_inval_tracker

// ===== rtl/ats_cmd_block.sv
// command handler for endpoint invalidates, page responses and access table invalidates
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - invalidate span is 4096 times 2^size, aligned, low address bits cleared.
// - address bits from 12 plus size upward go to the endpoint.
// - size 52 means all; larger sizes are flagged illegal here.
// - without substream support the index is ignored; sent without prefix.
// - with support and valid substream, prefix carries index; global needs valid.
// - endpoint invalidate illegal by queue versus feature and secure-disallow bits.
// - legal endpoint invalidate ignored without system support or translation off.
// - secure queue targets non-secure streams, realm queue targets realm streams.
// - invalidation completes only when a later sync barrier completes.
// - unsupported-request answer completes without any error.
// - page response goes to group index; code 3 is illegal.
// - page response illegal without page support or secure with disallow.
// - legal page response ignored without system support or translation off.
// - page response targets realm or non-secure streams by queue.
// - page response prefix follows the same substream rules.
// - invalidate-all clears the table cache of the queue's target state.
// - table invalidates illegal without table support or secure with disallow.
// - range base clears bits 11 to 0 and bits above output size.
// - four-bit range size decodes to ten spans; others do nothing.
// - range size given out whole so larger entries are covered.
// - leaf 0 clears all walk levels, leaf 1 only final level.
// - endpoint invalidates and page responses leave on the port.
module ats_cmd_block (
  input wire logic clk_in, // 200 MHz clock
  input wire logic rst_in, // async reset, high
  input wire logic [4:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  output logic ats_req_valid_out, // port request valid
  input wire logic ats_req_ready_in, // port takes request
  output logic ats_req_kind_out, // 0 invalidate, 1 page response
  output logic [31:0] ats_stream_out, // stream identifier
  output logic ats_realm_out, // realm stream
  output logic ats_pasid_valid_out, // prefix present
  output logic [19:0] ats_pasid_out, // substream index
  output logic ats_global_out, // global invalidate flag
  output logic [63:0] ats_addr_out, // invalidate address
  output logic [5:0] ats_size_out, // invalidate size
  output logic [8:0] ats_prg_out, // request group index
  output logic [1:0] ats_resp_out, // response code
  input wire logic ats_cpl_valid_in, // invalidate completion
  input wire logic ats_cpl_ur_in, // completion was unsupported
  output logic dpt_inv_valid_out, // table invalidate pulse
  output logic dpt_inv_all_out, // invalidate whole table cache
  output logic dpt_inv_realm_out, // realm target state
  output logic [63:0] dpt_base_out, // range base
  output logic [5:0] dpt_span_out, // log2 of range
  output logic dpt_leaf_out // final level only
);
  import ats_cmd_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    state_e st;
    logic wait_bus;
    logic [31:0] rdata;
    logic [31:0] cfg;
    logic [31:0] cmd;
    logic [31:0] stream;
    logic [31:0] subs;
    logic [63:0] addr;
    logic ill;
    logic sync_done;
    logic av;
    logic akind;
    logic [31:0] astream;
    logic arealm;
    logic apv;
    logic [19:0] apasid;
    logic aglob;
    logic [63:0] aaddr;
    logic [5:0] asize;
    logic [8:0] aprg;
    logic [1:0] aresp;
    logic dv;
    logic dall;
    logic drealm;
    logic [63:0] dbase;
    logic [5:0] dspan;
    logic dleaf;
  } blk_s;

  localparam blk_s BLK_RST = '{st: ST_IDLE, wait_bus: 1'b1, cfg: CONFIG_RST, default: '0};

  blk_s blk_reg;
  blk_s blk_next;
  logic [CNT_W-1:0] pend;
  logic [CNT_W-1:0] ur_cnt;
  logic inv_sent;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction : be_merge

  function automatic logic ten_for(input logic [31:0] cfg, input logic [1:0] q);
    logic t;
    t = 1'b0;
    if (q == Q_NS) begin
      t = cfg[CFG_TEN_NS];
    end else if (q == Q_SEC) begin
      t = cfg[CFG_TEN_S];
    end else if (q == Q_REALM) begin
      t = cfg[CFG_TEN_R];
    end
    return t;
  endfunction : ten_for

  // ==========================================================
  // next state
  always_comb begin
    logic req;
    logic stall;
    logic commit;
    logic clr_ill;
    logic clr_sync;
    logic set_ill;
    logic [31:0] rd;
    logic [2:0] op;
    logic [1:0] q;
    logic is_s;
    logic is_r;
    logic [5:0] sz;
    logic [6:0] n_lo;
    logic [6:0] sp;
    logic [63:0] base;
    logic [63:0] oas_mask;
    req = 1'b0;
    stall = 1'b0;
    commit = 1'b0;
    clr_ill = 1'b0;
    clr_sync = 1'b0;
    set_ill = 1'b0;
    rd = REG_RST;
    op = blk_reg.cmd[CMD_OP_LSB +: 3];
    q = blk_reg.cmd[CMD_Q_LSB +: 2];
    is_s = (q == Q_SEC);
    is_r = (q == Q_REALM);
    sz = blk_reg.cmd[CMD_SIZE_LSB +: 6];
    n_lo = PAGE_SHIFT + {1'b0, sz};
    sp = dpt_span(blk_reg.cmd[CMD_DSIZE_LSB +: 4]);
    oas_mask = (64'h0000_0000_0000_0001 << blk_reg.cfg[CFG_OAS_LSB +: 6]) -
               64'h0000_0000_0000_0001;
    base = blk_reg.addr & oas_mask & ~((64'h0000_0000_0000_0001 << PAGE_SHIFT) -
           64'h0000_0000_0000_0001);
    blk_next = blk_reg;
    blk_next.dv = 1'b0;

    // bus slave: one wait cycle, issue held off while a command runs
    req = avs_read_in || avs_write_in;
    stall = avs_write_in && (avs_address_in == OFF_ISSUE) && (blk_reg.st != ST_IDLE);
    commit = req && !blk_reg.wait_bus;
    if (avs_address_in == OFF_CONFIG) begin
      rd = blk_reg.cfg;
    end else if (avs_address_in == OFF_CMD) begin
      rd = blk_reg.cmd;
    end else if (avs_address_in == OFF_STREAM) begin
      rd = blk_reg.stream;
    end else if (avs_address_in == OFF_SUBSTREAM) begin
      rd = blk_reg.subs;
    end else if (avs_address_in == OFF_ADDR_LO) begin
      rd = blk_reg.addr[31:0];
    end else if (avs_address_in == OFF_ADDR_HI) begin
      rd = blk_reg.addr[63:32];
    end else if (avs_address_in == OFF_STATUS) begin
      rd[STAT_BUSY] = (blk_reg.st != ST_IDLE);
      rd[STAT_ILL] = blk_reg.ill;
      rd[STAT_SYNC] = blk_reg.sync_done;
      rd[STAT_PEND_LSB +: CNT_W] = pend;
      rd[STAT_UR_LSB +: CNT_W] = ur_cnt;
    end
    if (commit) begin
      blk_next.wait_bus = 1'b1;
    end else if (req && !stall) begin
      blk_next.wait_bus = 1'b0;
      blk_next.rdata = rd;
    end
    if (commit && avs_write_in) begin
      if (avs_address_in == OFF_CONFIG) begin
        blk_next.cfg = be_merge(blk_reg.cfg, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == OFF_CMD) begin
        blk_next.cmd = be_merge(blk_reg.cmd, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == OFF_STREAM) begin
        blk_next.stream = be_merge(blk_reg.stream, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == OFF_SUBSTREAM) begin
        blk_next.subs = be_merge(blk_reg.subs, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == OFF_ADDR_LO) begin
        blk_next.addr[31:0] = be_merge(blk_reg.addr[31:0], avs_writedata_in,
                                       avs_byteenable_in);
      end else if (avs_address_in == OFF_ADDR_HI) begin
        blk_next.addr[63:32] = be_merge(blk_reg.addr[63:32], avs_writedata_in,
                                        avs_byteenable_in);
      end else if (avs_address_in == OFF_ISSUE) begin
        blk_next.st = ST_EXEC;
      end else if (avs_address_in == OFF_STATUS) begin
        clr_ill = avs_writedata_in[STAT_ILL] && avs_byteenable_in[0];
        clr_sync = avs_writedata_in[STAT_SYNC] && avs_byteenable_in[0];
      end
    end

    // ==========================================================
    // command execution
    case (blk_reg.st)
      ST_EXEC: begin
        blk_next.st = ST_IDLE;
        case (op)
          OP_ATC_INV: begin
            if ((!is_r && !blk_reg.cfg[CFG_ATS]) || (is_s && blk_reg.cfg[CFG_SAD]) ||
                (is_r && !blk_reg.cfg[CFG_R_ATS]) || (q == 2'h3)) begin
              set_ill = 1'b1;
            end else if (sz > ATS_SIZE_MAX) begin
              set_ill = 1'b1;
            end else if (blk_reg.cfg[CFG_SYS_ATS] && ten_for(blk_reg.cfg, q)) begin
              blk_next.st = ST_SEND;
              blk_next.akind = KIND_INV;
              blk_next.astream = blk_reg.stream;
              blk_next.arealm = is_r;
              blk_next.apv = blk_reg.cmd[CMD_SSV] && blk_reg.cfg[CFG_PASID];
              blk_next.apasid = blk_next.apv ? blk_reg.subs[19:0] : 20'h0_0000;
              blk_next.aglob = blk_next.apv && blk_reg.cmd[CMD_GLOBAL];
              // size 52 shifts the mask out entirely: invalidate all
              blk_next.aaddr = blk_reg.addr & ~((64'h0000_0000_0000_0001 << n_lo) -
                               64'h0000_0000_0000_0001);
              blk_next.asize = sz;
              blk_next.aprg = 9'h000;
              blk_next.aresp = 2'h0;
            end
          end
          OP_PRI_RESP: begin
            if (!blk_reg.cfg[CFG_PRI] || (is_s && blk_reg.cfg[CFG_SAD]) ||
                (q == 2'h3)) begin
              set_ill = 1'b1;
            end else if (blk_reg.cmd[CMD_RESP_LSB +: 2] == RESP_RESERVED) begin
              set_ill = 1'b1;
            end else if (blk_reg.cfg[CFG_SYS_PRI] && ten_for(blk_reg.cfg, q)) begin
              blk_next.st = ST_SEND;
              blk_next.akind = KIND_PRG;
              blk_next.astream = blk_reg.stream;
              blk_next.arealm = is_r;
              blk_next.apv = blk_reg.cmd[CMD_SSV] && blk_reg.cfg[CFG_PASID];
              blk_next.apasid = blk_next.apv ? blk_reg.subs[19:0] : 20'h0_0000;
              blk_next.aglob = 1'b0;
              blk_next.aaddr = 64'h0000_0000_0000_0000;
              blk_next.asize = 6'h00;
              blk_next.aprg = blk_reg.cmd[CMD_PRG_LSB +: 9];
              blk_next.aresp = blk_reg.cmd[CMD_RESP_LSB +: 2];
            end
          end
          OP_DPT_ALL, OP_DPT_RANGE: begin
            if ((is_r && !blk_reg.cfg[CFG_R_DPT]) || (!is_r && !blk_reg.cfg[CFG_DPT]) ||
                (is_s && blk_reg.cfg[CFG_SAD]) || (q == 2'h3)) begin
              set_ill = 1'b1;
            end else if (op == OP_DPT_ALL) begin
              blk_next.dv = 1'b1;
              blk_next.dall = 1'b1;
              blk_next.drealm = is_r;
              blk_next.dbase = 64'h0000_0000_0000_0000;
              blk_next.dspan = 6'h00;
              blk_next.dleaf = 1'b0;
            end else if (sp[6] && ((base & ((64'h0000_0000_0000_0001 << sp[5:0]) -
                         64'h0000_0000_0000_0001)) == 64'h0000_0000_0000_0000)) begin
              blk_next.dv = 1'b1;
              blk_next.dall = 1'b0;
              blk_next.drealm = is_r;
              blk_next.dbase = base;
              blk_next.dspan = sp[5:0];
              blk_next.dleaf = blk_reg.cmd[CMD_LEAF];
            end
          end
          OP_SYNC: begin
            blk_next.st = ST_SYNC;
          end
          default: begin
            set_ill = 1'b1;
          end
        endcase
      end
      ST_SEND: begin
        blk_next.av = 1'b1;
        if (blk_reg.av && ats_req_ready_in) begin
          blk_next.av = 1'b0;
          blk_next.st = ST_IDLE;
        end
      end
      ST_SYNC: begin
        if (pend == '0) begin
          blk_next.sync_done = 1'b1;
          blk_next.st = ST_IDLE;
        end
      end
      default: begin
        blk_next.av = 1'b0;
      end
    endcase

    // a set in the same cycle as a clear wins
    blk_next.ill = (blk_reg.ill && !clr_ill) || set_ill;
    if (clr_sync && blk_next.st == blk_reg.st) begin
      blk_next.sync_done = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      blk_reg <= BLK_RST;
    end else begin
      blk_reg <= blk_next;
    end
  end

  // ==========================================================
  // outstanding invalidations
  assign inv_sent = blk_reg.av && ats_req_ready_in && (blk_reg.akind == KIND_INV);

  ats_inval_tracker u_tracker (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sent_in(inv_sent),
    .cpl_valid_in(ats_cpl_valid_in),
    .cpl_ur_in(ats_cpl_ur_in),
    .pend_out(pend),
    .ur_out(ur_cnt)
  );

  // ==========================================================
  // outputs
  assign avs_readdata_out = blk_reg.rdata;
  assign avs_waitrequest_out = blk_reg.wait_bus;
  assign ats_req_valid_out = blk_reg.av;
  assign ats_req_kind_out = blk_reg.akind;
  assign ats_stream_out = blk_reg.astream;
  assign ats_realm_out = blk_reg.arealm;
  assign ats_pasid_valid_out = blk_reg.apv;
  assign ats_pasid_out = blk_reg.apasid;
  assign ats_global_out = blk_reg.aglob;
  assign ats_addr_out = blk_reg.aaddr;
  assign ats_size_out = blk_reg.asize;
  assign ats_prg_out = blk_reg.aprg;
  assign ats_resp_out = blk_reg.aresp;
  assign dpt_inv_valid_out = blk_reg.dv;
  assign dpt_inv_all_out = blk_reg.dall;
  assign dpt_inv_realm_out = blk_reg.drealm;
  assign dpt_base_out = blk_reg.dbase;
  assign dpt_span_out = blk_reg.dspan;
  assign dpt_leaf_out = blk_reg.dleaf;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic [63:0] chk_mask;
  logic [2:0] chk_op;
  logic [1:0] chk_q;
  assign chk_mask = (64'h0000_0000_0000_0001 << (PAGE_SHIFT + {1'b0, blk_reg.asize})) -
                    64'h0000_0000_0000_0001;
  assign chk_op = blk_reg.cmd[CMD_OP_LSB +: 3];
  assign chk_q = blk_reg.cmd[CMD_Q_LSB +: 2];

  atc_low_zero_a: assert property (
    blk_reg.av && blk_reg.akind == KIND_INV |-> (blk_reg.aaddr & chk_mask) == '0)
    else $error("invalidate address has bits set below the span");
  atc_size_max_a: assert property (
    blk_reg.av && blk_reg.akind == KIND_INV |-> blk_reg.asize <= ATS_SIZE_MAX)
    else $error("invalidate sent with size above the full span");
  global_needs_prefix_a: assert property (
    blk_reg.av |-> !blk_reg.aglob || blk_reg.apv)
    else $error("global flag without substream prefix");
  atc_realm_ill_a: assert property (
    blk_reg.st == ST_EXEC && chk_op == OP_ATC_INV && chk_q == Q_REALM &&
    !blk_reg.cfg[CFG_R_ATS] |=> blk_reg.ill && blk_reg.st == ST_IDLE)
    else $error("realm invalidate without realm support not flagged");
  sync_waits_a: assert property (
    $rose(blk_reg.sync_done) |-> $past(pend) == '0)
    else $error("sync completed with invalidations outstanding");
  ur_no_error_a: assert property (
    ats_cpl_valid_in && ats_cpl_ur_in && blk_reg.st != ST_EXEC && !blk_reg.ill
    |=> !blk_reg.ill)
    else $error("unsupported answer raised the error flag");
  resp_reserved_a: assert property (
    blk_reg.st == ST_EXEC && chk_op == OP_PRI_RESP &&
    blk_reg.cmd[CMD_RESP_LSB +: 2] == RESP_RESERVED |=> blk_reg.ill ##1 !blk_reg.av)
    else $error("reserved response code was not refused");
  pri_absent_a: assert property (
    blk_reg.st == ST_EXEC && chk_op == OP_PRI_RESP && !blk_reg.cfg[CFG_PRI]
    |=> blk_reg.ill && blk_reg.st == ST_IDLE)
    else $error("page response without page support not flagged");
  dpt_secure_ill_a: assert property (
    blk_reg.st == ST_EXEC && (chk_op == OP_DPT_ALL || chk_op == OP_DPT_RANGE) &&
    chk_q == Q_SEC && blk_reg.cfg[CFG_SAD] |=> blk_reg.ill && !blk_reg.dv)
    else $error("secure table invalidate with disallow not refused");
  dpt_base_low_a: assert property (
    blk_reg.dv && !blk_reg.dall |-> blk_reg.dbase[11:0] == 12'h000 &&
    blk_reg.dspan >= PAGE_SHIFT[5:0])
    else $error("range base or span out of form");
  port_hold_a: assert property (
    blk_reg.av && !ats_req_ready_in |=> blk_reg.av && $stable(blk_reg.aaddr) &&
    $stable(blk_reg.akind))
    else $error("port request dropped or changed before taken");

  atc_sent_c: cover property (blk_reg.av && ats_req_ready_in && blk_reg.akind == KIND_INV);
  prg_sent_c: cover property (blk_reg.av && ats_req_ready_in && blk_reg.akind == KIND_PRG);
  dpt_range_c: cover property (blk_reg.dv && !blk_reg.dall);
  sync_done_c: cover property ($rose(blk_reg.sync_done));

endmodule : ats_cmd_block

// ===== tb/ats_port_model.sv
// far-end model: takes ats requests after a stall, returns completions
`timescale 1ns/1ps
module ats_port_model (
  input wire logic clk_in, // clock
  input wire logic rst_in, // async reset, high
  input wire logic valid_in, // request valid
  input wire logic kind_in, // 0 invalidate
  input wire logic ur_in, // answer unsupported
  output logic ready_out, // request taken
  output logic cpl_valid_out, // completion pulse
  output logic cpl_ur_out // completion is ur
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_reg <= 2'h0;
      ready_out <= 1'b0;
      cpl_valid_out <= 1'b0;
      cpl_ur_out <= 1'b0;
    end else begin
      wait_reg <= (valid_in && !ready_out) ? wait_reg + 2'h1 : 2'h0;
      ready_out <= valid_in && !ready_out && wait_reg == 2'h2;
      cpl_valid_out <= valid_in && ready_out && !kind_in;
      cpl_ur_out <= valid_in && ready_out && ur_in;
    end
  end
endmodule : ats_port_model

// ===== tb/ats_cmd_block_test.sv
// self-checking bench for the ats command block
`timescale 1ns/1ps
module ats_cmd_block_test;
  import ats_cmd_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0, ur = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, ats_stream_out, rdat;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic avs_waitrequest_out, ats_req_valid_out, ats_req_ready_in, ats_req_kind_out;
  logic ats_realm_out, ats_pasid_valid_out, ats_global_out, ats_cpl_valid_in, ats_cpl_ur_in;
  logic dpt_inv_valid_out, dpt_inv_all_out, dpt_inv_realm_out, dpt_leaf_out;
  logic [19:0] ats_pasid_out;
  logic [63:0] ats_addr_out, dpt_base_out;
  logic [5:0] ats_size_out, dpt_span_out;
  logic [8:0] ats_prg_out;
  logic [1:0] ats_resp_out;
  int checked = 0, num_errors = 0, cyc = 0;
  always #2.5 clk_in = ~clk_in;
  ats_cmd_block ats_cmd_block_i (.*);
  ats_port_model ats_port_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .valid_in(ats_req_valid_out), .kind_in(ats_req_kind_out), .ur_in(ur),
    .ready_out(ats_req_ready_in), .cpl_valid_out(ats_cpl_valid_in), .cpl_ur_out(ats_cpl_ur_in));
  // ========
  // shared tasks
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic issue(input logic [31:0] cfg, input logic [31:0] c, input logic [63:0] a);
    bus(1'b1, OFF_CONFIG, cfg | CONFIG_RST);
    bus(1'b1, OFF_CMD, c);
    bus(1'b1, OFF_STREAM, 32'h0000_0055);
    bus(1'b1, OFF_SUBSTREAM, 32'h000a_bcde);
    bus(1'b1, OFF_ADDR_LO, a[31:0]);
    bus(1'b1, OFF_ADDR_HI, a[63:32]);
    bus(1'b1, OFF_ISSUE, 32'h0000_0001);
  endtask : issue
  // ========
  // scenarios
  task automatic t_atc();
    ur <= 1'b1;
    issue(32'h0000_0289, 32'h0000_0cc1, 64'h1234_5678_9abc_def0); // local caches clean
    do @(negedge clk_in); while (ats_req_valid_out !== 1'b1);
    chk("atc addr", ats_addr_out, 64'h1234_5678_9abc_8000);
    chk("atc stream", ats_stream_out, 32'h0000_0055);
    chk("atc fields", {ats_req_kind_out, ats_realm_out, ats_pasid_valid_out, ats_global_out,
      ats_size_out, ats_pasid_out}, {4'h3, 6'h03, 20'habcde});
    do @(negedge clk_in); while (ats_cpl_valid_in !== 1'b1);
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    ur <= 1'b0;
    chk("atc status", {rdat[23:16], rdat[1]}, 9'h002);
    bus(1'b1, OFF_CMD, 32'h0000_0005);
    bus(1'b1, OFF_ISSUE, 32'h0000_0001);
    do bus(1'b0, OFF_STATUS, 32'h0000_0000); while (rdat[0] !== 1'b0);
    chk("sync done", rdat[2:1], 2'h2);
    $display("end atc");
  endtask : t_atc
  task automatic t_ill();
    logic [63:0] tab [8] = '{64'h0000_0000_0000_0001, 64'h0000_0041_0000_0011,
      64'h0000_0001_0000_0021, 64'h0000_0104_0000_0302, 64'h0000_0050_0000_0013,
      64'h0000_0281_0000_d401, 64'h0000_0000_0000_0002, 64'h0000_0000_0000_0006};
    foreach (tab[i]) begin
      issue(tab[i][63:32], tab[i][31:0], 64'h0000_0000_0000_0000);
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      chk("illegal flag", rdat[1], 1'b1);
      chk("illegal idle", {ats_req_valid_out, dpt_inv_valid_out}, 2'h0);
      bus(1'b1, OFF_STATUS, 32'h0000_0002);
    end
    issue(32'h0000_0001, 32'h0000_0001, 64'h0000_0000_0000_0000);
    bus(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("ignored", {rdat[1:0], ats_req_valid_out}, 3'h0);
    $display("end illegal");
  endtask : t_ill
  task automatic t_pri();
    issue(32'h0000_0904, 32'h34a0_0222, 64'h0000_0000_0000_0000);
    do @(negedge clk_in); while (ats_req_valid_out !== 1'b1);
    chk("pri fields", {ats_req_kind_out, ats_realm_out, ats_pasid_valid_out, ats_prg_out,
      ats_resp_out}, {3'h6, 9'h1a5, 2'h2});
    $display("end pri");
  endtask : t_pri
  task automatic t_dpt();
    issue(32'h0000_0010, 32'h0013_0004, 64'hffff_0000_0020_0fff);
    do @(negedge clk_in); while (dpt_inv_valid_out !== 1'b1);
    chk("dpt base", dpt_base_out, 64'h0000_0000_0020_0000);
    chk("dpt fields", {dpt_inv_all_out, dpt_inv_realm_out, dpt_leaf_out, dpt_span_out},
      {3'h1, 6'h15});
    issue(32'h0000_0020, 32'h0000_0023, 64'h0000_0000_0000_0000);
    do @(negedge clk_in); while (dpt_inv_valid_out !== 1'b1);
    chk("dpt all", {dpt_inv_all_out, dpt_inv_realm_out}, 2'h3);
    $display("end dpt");
  endtask : t_dpt
  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, OFF_CONFIG, 32'h0000_0000);
    chk("config reset", rdat, CONFIG_RST);
    t_atc();
    t_ill();
    t_pri();
    t_dpt();
    summarize();
  end
endmodule : ats_cmd_block_test
